// ===== bench/framer_model.sv
`timescale 1ns/1ps
// Framer stand-in: takes a frame after a stall, then is busy 4 cycles.
module framer_model (
    input wire core_clk,
    input wire rst,
    input wire frame_valid,
    input wire [3:0] stall,
    output reg frame_ready,
    output wire frame_in_flight
);
    reg [3:0] wait_reg; // Cycles the offer has waited.
    reg [2:0] busy_reg; // Cycles left on the line.
    assign frame_in_flight = busy_reg != 3'h0;
    // One cycle of ready per frame, never while the line is busy.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wait_reg <= 4'h0;
            busy_reg <= 3'h0;
            frame_ready <= 1'b0;
        end else begin
            wait_reg <= (frame_valid && !frame_ready) ? wait_reg + 4'h1 : 4'h0;
            frame_ready <= frame_valid && !frame_ready && wait_reg >= stall
                && !frame_in_flight;
            busy_reg <= (frame_valid && frame_ready) ? 3'h4
                : busy_reg - {2'h0, frame_in_flight};
        end
    end
endmodule

// ===== bench/tb_tx_pause_frame_request.sv
`timescale 1ns/1ps
module tb_tx_pause_frame_request;
    reg core_clk = 1'b0;
    reg rst = 1'b1;
    reg [8:0] req = 9'h000; // Request levels, held at least 16 cycles each.
    reg resend = 1'b0;
    reg [3:0] stall = 4'h2; // Framer accept delay.
    reg [15:0] q [0:8];
    reg [15:0] iv [0:8];
    wire frame_valid, frame_ready, frame_in_flight, frame_kind;
    wire [7:0] en_w;
    wire [127:0] fq_w;
    wire [8:0] st_w;
    reg kind, seen;
    reg [7:0] en;
    reg [127:0] fq;
    reg [8:0] st;
    integer fails = 0, n_tests = 0, gap, i;
    tx_pause_frame_request dut (.core_clk(core_clk), .rst(rst),
        .pause_request_bus(req), .resend_pending_pulse(resend),
        .priority0_quanta_value(q[0]), .priority1_quanta_value(q[1]),
        .priority2_quanta_value(q[2]), .priority3_quanta_value(q[3]),
        .priority4_quanta_value(q[4]), .priority5_quanta_value(q[5]),
        .priority6_quanta_value(q[6]), .priority7_quanta_value(q[7]),
        .global_quanta_value(q[8]), .global_refresh_interval(iv[8]),
        .priority0_refresh_interval(iv[0]), .priority1_refresh_interval(iv[1]),
        .priority2_refresh_interval(iv[2]), .priority3_refresh_interval(iv[3]),
        .priority4_refresh_interval(iv[4]), .priority5_refresh_interval(iv[5]),
        .priority6_refresh_interval(iv[6]), .priority7_refresh_interval(iv[7]),
        .frame_valid(frame_valid), .frame_ready(frame_ready),
        .frame_in_flight(frame_in_flight), .frame_kind(frame_kind),
        .frame_class_enable(en_w), .frame_quanta(fq_w),
        .pause_sent_status(st_w));
    framer_model fm (.core_clk(core_clk), .rst(rst), .stall(stall),
        .frame_valid(frame_valid), .frame_ready(frame_ready),
        .frame_in_flight(frame_in_flight));
    initial forever #5 core_clk = ~core_clk;
    task chk(input [127:0] seen_v, input [127:0] exp, input [63:0] nm);
        begin
            n_tests = n_tests + 1;
            if (seen_v !== exp) begin
                fails = fails + 1;
                $display("CHECK FAILED %0s exp %0h seen %0h", nm, exp, seen_v);
            end
        end
    endtask
    task wrap_up;
        begin
            $display("Checks %0d, mismatches %0d", n_tests, fails);
            if (fails == 0 && n_tests > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    // Waits for a frame to be taken, captures it and the status after.
    task take;
        begin
            gap = 0;
            while (gap < 90 && !(frame_valid === 1'b1 && frame_ready === 1'b1))
            begin
                @(negedge core_clk);
                gap = gap + 1;
            end
            if (!(frame_valid === 1'b1 && frame_ready === 1'b1)) begin
                fails = fails + 1;
                wrap_up;
            end
            kind = frame_kind;
            en = en_w;
            fq = fq_w;
            @(negedge core_clk);
            st = st_w;
        end
    endtask
    // Each priority alone carries its own quanta and status bit.
    task sc_prio;
        integer p;
        begin
            for (p = 0; p < 8; p = p + 1) begin
                req[p] = 1'b1;
                take;
                chk(kind, 0, "kind");
                chk(en, 1 << p, "enable");
                chk(fq[16*p +: 16], q[p], "quanta");
                chk(st, 1 << p, "status");
                repeat (16) @(negedge core_clk);
                req[p] = 1'b0;
                repeat (16) @(negedge core_clk);
            end
        end
    endtask
    // A held request repeats after its interval and stops when dropped.
    task sc_refresh(input integer c);
        begin
            req[c] = 1'b1;
            take;
            take;
            chk(gap + 4 >= iv[c] && gap <= iv[c] + 12, 1, "refresh");
            chk(kind, c == 8, "kind");
            chk(fq[16*(c%8) +: 16], q[c], "quanta");
            req[c] = 1'b0;
            seen = 1'b0;
            repeat (10) @(negedge core_clk);
            repeat (60) @(negedge core_clk) seen = seen | frame_valid;
            chk(seen, 0, "stopped");
        end
    endtask
    // A resend pulse repeats a pending frame long before its interval.
    task sc_resend;
        begin
            stall = 4'h6;
            req[5] = 1'b1;
            take;
            resend = 1'b1;
            @(negedge core_clk);
            resend = 1'b0;
            take;
            chk(gap < 30, 1, "resend");
            chk(st, 9'h020, "status");
            repeat (16) @(negedge core_clk);
            req[5] = 1'b0;
        end
    endtask
    initial begin
        for (i = 0; i < 9; i = i + 1) begin
            q[i] = 16'hA000 + i * 16'h0111;
            iv[i] = (i == 2 || i == 8) ? 16'h0028 : 16'h0FFF;
        end
        repeat (5) @(negedge core_clk);
        rst = 1'b0;
        sc_prio;
        sc_refresh(2);
        sc_refresh(8);
        sc_resend;
        wrap_up;
    end
endmodule

// ===== bench/tx_pause_chk_chk.sv
`timescale 1ns/1ps
// Ties each frame offer to its cause at the request and value inputs.
module tx_pause_chk #(parameter QW = 16) (
    // Clock, reset and watched ports.
    input wire core_clk,
    input wire rst,
    input wire [8:0] pause_request_bus,
    input wire [QW-1:0] priority3_quanta_value,
    input wire [QW-1:0] global_quanta_value,
    input wire frame_valid,
    input wire frame_ready,
    input wire frame_kind,
    input wire [7:0] frame_class_enable,
    input wire [8*QW-1:0] frame_quanta,
    input wire [8:0] pause_sent_status
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // A frame handed to the framer.
    sequence take_s;
        frame_valid && frame_ready;
    endsequence
    hold_offer_a: assert property (
        frame_valid && !frame_ready |=> frame_valid && $stable(frame_quanta))
        else $error("Offer changed.");
    global_quanta_a: assert property (frame_valid && frame_kind |->
        frame_quanta[QW-1:0] == global_quanta_value) else $error("Global.");
    prio_quanta_a: assert property (
        frame_valid && !frame_kind && frame_class_enable[3] |->
        frame_quanta[4*QW-1:3*QW] == priority3_quanta_value) else $error("Q3.");
    prio_enable_a: assert property (
        frame_valid && !frame_kind |-> frame_class_enable != 8'h00)
        else $error("Empty.");
    global_sent_a: assert property (take_s ##0 frame_kind |=>
        pause_sent_status == 9'h100 ##1 pause_sent_status == 9'h000)
        else $error("Global status.");
    prio_sent_a: assert property (take_s ##0 !frame_kind |=>
        pause_sent_status == {1'b0, $past(frame_class_enable)})
        else $error("Status.");
    status_cause_a: assert property (pause_sent_status != 9'h000 |->
        $past(frame_valid) && $past(frame_ready)) else $error("Stray.");
    global_answer_a: assert property ($rose(pause_request_bus[8]) |->
        ##[1:40] frame_valid && frame_kind) else $error("No global.");
endmodule
bind tx_pause_frame_request tx_pause_chk #(.QW(QW)) chk (.*);

// ===== rtl/refresh_timer.v
`timescale 1ns/1ps
// One class's refresh countdown: it asks for a frame when the request
// rises, and again each time the interval expires while still requested.
module refresh_timer #(
    parameter W = 16
) (
    // Clock and reset.
    input wire core_clk,
    input wire rst,
    // Class control.
    input wire request,
    input wire [W-1:0] interval,
    input wire restart,
    input wire sent,
    // Pending flag for the scheduler.
    output wire pending
);
    reg [W-1:0] count_reg;   // Cycles left before the next refresh.
    reg pend_reg;            // A frame for this class is owed.
    reg req_d_reg;           // Request seen last cycle.
    reg armed_reg;           // Countdown is running.

    assign pending = pend_reg;

    // Countdown and pending flag; a new need wins over a same-cycle send.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            count_reg <= {W{1'b0}};
            pend_reg <= 1'b0;
            req_d_reg <= 1'b0;
            armed_reg <= 1'b0;
        end else begin
            req_d_reg <= request;
            if (!request) begin
                // Stop scheduling refreshes; an owed frame may still go.
                armed_reg <= 1'b0;
                if (sent) begin
                    pend_reg <= 1'b0;
                end
            end else if (restart || !req_d_reg) begin
                // Rising request or resend: owe a frame, restart count.
                pend_reg <= 1'b1;
                count_reg <= interval;
                armed_reg <= 1'b1;
            end else if (armed_reg && count_reg == {W{1'b0}}) begin
                // Interval expired while still requested.
                pend_reg <= 1'b1;
                count_reg <= interval;
            end else begin
                if (armed_reg) begin
                    count_reg <= count_reg - {{(W-1){1'b0}}, 1'b1};
                end
                if (sent) begin
                    pend_reg <= 1'b0;
                end
            end
        end
    end
endmodule

// ===== rtl/tx_pause_frame_request.v
`timescale 1ns/1ps
`include "pause_tx_regs.vh"
module tx_pause_frame_request #(
    // Width of every quanta and interval value.
    parameter QW = `QUANTA_W
) (
    // Clock and reset.
    input wire core_clk,
    input wire rst,
    // Pause request controls from user logic. All of them are levels in
    // the transmit clock domain; requests sampled on every edge, quanta as an offer opens.
    input wire [8:0] pause_request_bus,
    input wire [QW-1:0] priority0_quanta_value,
    input wire [QW-1:0] priority1_quanta_value,
    input wire [QW-1:0] priority2_quanta_value,
    input wire [QW-1:0] priority3_quanta_value,
    input wire [QW-1:0] priority4_quanta_value,
    input wire [QW-1:0] priority5_quanta_value,
    input wire [QW-1:0] priority6_quanta_value,
    input wire [QW-1:0] priority7_quanta_value,
    input wire [QW-1:0] global_quanta_value,
    // Refresh intervals in clock cycles, one per class.
    input wire [QW-1:0] priority0_refresh_interval,
    input wire [QW-1:0] priority1_refresh_interval,
    input wire [QW-1:0] priority2_refresh_interval,
    input wire [QW-1:0] priority3_refresh_interval,
    input wire [QW-1:0] priority4_refresh_interval,
    input wire [QW-1:0] priority5_refresh_interval,
    input wire [QW-1:0] priority6_refresh_interval,
    input wire [QW-1:0] priority7_refresh_interval,
    input wire [QW-1:0] global_refresh_interval,
    // One-cycle resend request.
    input wire resend_pending_pulse,
    // Frame request to the transmit framer. The offer stands until the
    // framer's ready, and the frame data stands with it.
    output wire frame_valid,
    input wire frame_ready,
    input wire frame_in_flight,
    output reg frame_kind,
    output reg [7:0] frame_class_enable,
    output reg [8*QW-1:0] frame_quanta,
    // Transmitted pause status.
    // One-cycle pulse per class, in the cycle after the hand-over.
    output reg [8:0] pause_sent_status
);
    // States of the frame scheduler, one-hot. IDLE looks for owed classes,
    // OFFER holds one frame on the framer port until it is taken, and DONE
    // gives the per-class timers one cycle to drop their pending flags so
    // the same class is not offered twice for one need.
    localparam [2:0] ST_IDLE = 3'h1; // Waiting for an owed class.
    localparam [2:0] ST_OFFER = 3'h2; // Frame offered to the framer.
    localparam [2:0] ST_DONE = 3'h4; // Settling after a hand-over.

    // Scheduler and resend bookkeeping.
    reg [2:0] state_reg; // Scheduler state.
    reg resend_hold_reg; // Resend seen, waiting for idle line.
    reg [8:0] sent_reg; // One-cycle send strobes per class.
    // Per-class flags and flattened value buses, class 8 on top.
    wire [8:0] pending; // Owed frames per class.
    wire [QW*9-1:0] quanta_all; // Quanta of all classes.
    wire [QW*9-1:0] interval_all; // Refresh intervals of all classes.
    wire restart; // Resend takes effect this cycle.

    // Status and retire vector of a frame: only the global class for a
    // global frame, otherwise one bit per priority the frame carries.
    // Both the status pulse and the timers' send strobes use it, so the
    // two can never disagree about which classes were served.
    function [8:0] sent_vector;
        input kind;
        input [7:0] enable;
        begin
            if (kind == `KIND_GLOBAL) begin
                // Global frames report on the top bit alone.
                sent_vector = 9'h100;
            end else begin
                // Priority frames report every class they carry.
                sent_vector = {1'b0, enable};
            end
        end
    endfunction

    // Gather the per-class quanta into one bus so the scheduler can pick a
    // slot by class index; the global value sits in slot 8.
    assign quanta_all = {global_quanta_value, priority7_quanta_value,
        priority6_quanta_value, priority5_quanta_value,
        priority4_quanta_value, priority3_quanta_value,
        priority2_quanta_value, priority1_quanta_value,
        priority0_quanta_value};
    // Gather the refresh intervals the same way; each timer takes its own
    // slot, and slot 8 times the global class.
    assign interval_all = {global_refresh_interval,
        priority7_refresh_interval, priority6_refresh_interval,
        priority5_refresh_interval, priority4_refresh_interval,
        priority3_refresh_interval, priority2_refresh_interval,
        priority1_refresh_interval, priority0_refresh_interval};

    // A resend takes effect only once the frame in flight completes. A
    // pulse that lands on an idle line acts at once; one that lands on a
    // busy line is held and acts in the first cycle the line is free.
    assign restart = (resend_hold_reg || resend_pending_pulse) &&
        !frame_in_flight;

    // One refresh timer per class. Each timer owns one bit of the pending
    // bus; the scheduler retires a class through its send strobe.
    genvar g; // Class index of the timer array.
    generate
        for (g = 0; g < `PAUSE_CLASSES; g = g + 1) begin : cls
            refresh_timer #(.W(QW)) u_timer (
                .core_clk(core_clk),
                .rst(rst),
                .request(pause_request_bus[g]),
                .interval(interval_all[g*QW +: QW]),
                .restart(restart),
                .sent(sent_reg[g]),
                .pending(pending[g])
            );
        end
    endgenerate

    // The offer is a plain decode of the state so that it drops in the
    // cycle after the framer's ready, with no extra register in the way.
    assign frame_valid = (state_reg == ST_OFFER);

    // Hold a resend pulse until the line is free.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            // No resend is owed out of reset.
            resend_hold_reg <= 1'b0;
        end else if (resend_pending_pulse && frame_in_flight) begin
            // Line busy: remember the pulse.
            resend_hold_reg <= 1'b1;
        end else if (!frame_in_flight) begin
            // Line free: a held pulse has just been applied.
            resend_hold_reg <= 1'b0;
        end
    end

    // Scheduler: global frames first, then all owed priorities together.
    // Priority classes owed at the same time share one frame, each slot
    // carrying its own quanta; the frame data is captured as the offer
    // opens and then holds still until the framer takes it.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            // All outputs idle out of reset.
            state_reg <= ST_IDLE;
            frame_kind <= `KIND_PRIORITY;
            frame_class_enable <= 8'h00;
            frame_quanta <= {(8*QW){1'b0}};
            sent_reg <= 9'h000;
            pause_sent_status <= 9'h000;
        end else begin
            // Strobes last one cycle unless set again below.
            sent_reg <= 9'h000;
            pause_sent_status <= 9'h000;
            case (state_reg)
                ST_IDLE: begin
                    if (pending[`GLOBAL_CLASS]) begin
                        // Global frame with the global quanta.
                        frame_kind <= `KIND_GLOBAL;
                        frame_class_enable <= 8'h00;
                        frame_quanta <= {{(7*QW){1'b0}},
                            quanta_all[8*QW +: QW]};
                        state_reg <= ST_OFFER;
                    end else if (pending[7:0] != 8'h00) begin
                        // Priority frame, each slot its own quanta.
                        frame_kind <= `KIND_PRIORITY;
                        frame_class_enable <= pending[7:0];
                        frame_quanta <= quanta_all[8*QW-1:0];
                        state_reg <= ST_OFFER;
                    end else begin
                        // Nothing owed: stay idle.
                        state_reg <= ST_IDLE;
                    end
                end
                ST_OFFER: begin
                    // Frame data holds while the framer stalls.
                    if (frame_ready) begin
                        // Framer took it: report and retire the classes.
                        sent_reg <= sent_vector(frame_kind,
                            frame_class_enable);
                        pause_sent_status <= sent_vector(frame_kind,
                            frame_class_enable);
                        state_reg <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    // One settling cycle so pending flags drop.
                    // A class still requested re-arms through its timer.
                    state_reg <= ST_IDLE;
                end
                default: begin
                    // An illegal code falls back to idle.
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

// ===== shared/pause_tx_regs.vh
`ifndef PAUSE_TX_REGS_VH
`define PAUSE_TX_REGS_VH
// Number of pause classes: eight priorities plus one global class.
`define PAUSE_CLASSES 9
// Index of the global pause class on every class-wide bus.
`define GLOBAL_CLASS 4'h8
// Width of quanta and refresh interval values.
`define QUANTA_W 16
// Steady time the requester must give each request bit, in cycles.
`define REQ_STEADY_CYCLES 16
// Frame kind codes on the frame request port.
`define KIND_PRIORITY 1'h0
`define KIND_GLOBAL 1'h1
// Class-enable vector length for a priority frame.
`define PRIO_VEC_W 8
`endif
